// file: src/cepb_dpram.sv
// Dual-port byte-writable memory with registered read data
`timescale 1ns/1ps
module cepb_dpram import cepb_pkg::*; #(
   parameter int AW = MEM_AW,
   parameter int DW = MEM_DW
) (
   input wire logic clk,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [DW/8-1:0] wr_be,
   input wire logic [DW-1:0] wr_data,
   input wire logic rd_en,
   input wire logic [AW-1:0] rd_addr,
   output logic [DW-1:0] rd_data
);
   logic [DW-1:0] mem [2**AW];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         for (int b = 0; b < DW/8; b++) begin
            if (wr_be[b]) begin
               mem[wr_addr][8*b +: 8] <= wr_data[8*b +: 8];
            end
         end
      end
   end

   // Read data holds while rd_en is low, which lets a stalled stream keep its word
   always_ff @(posedge clk) begin
      if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule // cepb_dpram

// file: src/cepb_pkg.sv
// Package: constants, types and helpers for the packet buffer
package cepb_pkg;
   localparam int MEM_AW = 6;
   localparam int MEM_DW = 512;
   localparam int MEM_BE = 64;
   localparam int LEN_W = 13;
   localparam int HDR_BYTES = 38;
   localparam int HDR_WORDS = 10;
   localparam int FIFO_AW = 4;
   localparam int FIFO_CW = 5;
   localparam int PADDR_W = 14;

   localparam logic [13:0] OFS_CTRL = 14'h0000;
   localparam logic [13:0] OFS_TX_LEN = 14'h0004;
   localparam logic [13:0] OFS_STATUS = 14'h0008;
   localparam logic [13:0] OFS_FIFO_HEAD = 14'h000C;
   localparam logic [13:0] OFS_HDR_BASE = 14'h0040;
   localparam logic [13:0] OFS_MASK_LO = 14'h0068;
   localparam logic [13:0] OFS_MASK_HI = 14'h006C;
   localparam logic [1:0] OFS_TXMEM_TOP = 2'h1;
   localparam logic [1:0] OFS_RXMEM_TOP = 2'h2;

   localparam int CTRL_TX_REQ_BIT = 0;
   localparam int CTRL_RX_EN_BIT = 1;
   localparam int CTRL_POP_BIT = 2;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_EMPTY_BIT = 1;
   localparam int STAT_FILL_POS = 4;

   localparam logic [LEN_W-1:0] TX_LEN_RST = 13'h0000;
   localparam logic [63:0] KEEP_ALL = 64'hFFFF_FFFF_FFFF_FFFF;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_FETCH = 2'b01,
      TX_SEND = 2'b10
   } cepb_tx_e;

   typedef enum logic [2:0] {
      RG_NONE = 3'b000,
      RG_CTRL = 3'b001,
      RG_LEN = 3'b010,
      RG_STAT = 3'b011,
      RG_HEAD = 3'b100,
      RG_HDR = 3'b101,
      RG_TXMEM = 3'b110,
      RG_RXMEM = 3'b111
   } cepb_rg_e;

   typedef struct packed {
      logic valid;
      logic last;
      logic [MEM_DW-1:0] data;
   } cepb_rx_s;

   function automatic cepb_rg_e cepb_region(input logic [13:0] a);
      if (a[13:12] == OFS_TXMEM_TOP) return RG_TXMEM;
      if (a[13:12] == OFS_RXMEM_TOP) return RG_RXMEM;
      if (a == OFS_CTRL) return RG_CTRL;
      if (a == OFS_TX_LEN) return RG_LEN;
      if (a == OFS_STATUS) return RG_STAT;
      if (a == OFS_FIFO_HEAD) return RG_HEAD;
      if (a >= OFS_HDR_BASE && a <= OFS_MASK_HI && a[1:0] == 2'h0) return RG_HDR;
      return RG_NONE;
   endfunction

   // Zero remainder means the final word is full
   function automatic logic [63:0] cepb_last_mask(input logic [5:0] r);
      if (r == 6'h00) return KEEP_ALL;
      return (64'h1 << r) - 64'h1;
   endfunction
endpackage

// file: src/cepb_top.sv
// Packet buffer top: APB registers, transmit streamer, receive filter and store
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module cepb_top import cepb_pkg::*; (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic tx_word_valid,
   output logic tx_final_word,
   output logic [MEM_BE-1:0] tx_byte_keep,
   output logic [MEM_DW-1:0] tx_word_data,
   input wire logic tx_word_accept,
   input wire cepb_rx_s rx_in
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   // Bus slave: every access takes one wait state so reads of memory settle
   cepb_rg_e region;
   logic acc_phase;
   logic wr_fire;
   logic [31:0] rd_value;
   assign region = cepb_region(paddr);
   assign acc_phase = psel & penable & ~pready;
   assign wr_fire = psel & penable & pready & pwrite & ce;

   // Host-visible state
   logic [LEN_W-1:0] tx_byte_length;
   logic rx_accept_enable;
   logic [31:0] hdr_word [HDR_WORDS];
   logic [HDR_BYTES-1:0] header_byte_mask;
   logic tx_in_progress;
   logic end_fifo_empty;
   logic [FIFO_CW-1:0] end_fifo_fill_count;
   logic [MEM_AW-1:0] end_fifo_head;
   logic [MEM_DW-1:0] rx_mem_rdata;
   logic [3:0] rx_lane;
   logic end_fifo_pop;
   logic tx_go;
   logic [3:0] hdr_idx;

   assign rx_lane = paddr[5:2];
   assign hdr_idx = 4'(paddr[6:2] - 5'h10);
   assign tx_go = wr_fire & (region == RG_CTRL) & pwdata[CTRL_TX_REQ_BIT] & ~tx_in_progress;
   assign end_fifo_pop = wr_fire & (region == RG_CTRL) & pwdata[CTRL_POP_BIT] & ~end_fifo_empty;

   always_comb begin
      rd_value = 32'h0000_0000;
      case (region)
         RG_CTRL: rd_value[CTRL_RX_EN_BIT] = rx_accept_enable;
         RG_LEN: rd_value[LEN_W-1:0] = tx_byte_length;
         RG_STAT: begin
            rd_value[STAT_BUSY_BIT] = tx_in_progress;
            rd_value[STAT_EMPTY_BIT] = end_fifo_empty;
            rd_value[STAT_FILL_POS +: FIFO_CW] = end_fifo_fill_count;
         end
         RG_HEAD: rd_value[MEM_AW-1:0] = end_fifo_head;
         RG_HDR: begin
            if (paddr == OFS_MASK_LO) rd_value = header_byte_mask[31:0];
            else if (paddr == OFS_MASK_HI) rd_value[5:0] = header_byte_mask[37:32];
            else rd_value = hdr_word[hdr_idx];
         end
         RG_RXMEM: rd_value = rx_mem_rdata[32*rx_lane +: 32];
         default: rd_value = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (ce) begin
         pready <= acc_phase;
         pslverr <= acc_phase & (region == RG_NONE);
         if (acc_phase) prdata <= pwrite ? 32'h0000_0000 : rd_value;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         tx_byte_length <= TX_LEN_RST;
         rx_accept_enable <= 1'b0;
         header_byte_mask <= '0;
         for (int i = 0; i < HDR_WORDS; i++) hdr_word[i] <= 32'h0000_0000;
      end else if (wr_fire) begin
         if (region == RG_LEN) tx_byte_length <= pwdata[LEN_W-1:0];
         if (region == RG_CTRL) rx_accept_enable <= pwdata[CTRL_RX_EN_BIT];
         if (region == RG_HDR) begin
            if (paddr == OFS_MASK_LO) header_byte_mask[31:0] <= pwdata;
            else if (paddr == OFS_MASK_HI) header_byte_mask[37:32] <= pwdata[5:0];
            else hdr_word[hdr_idx] <= pwdata;
         end
      end
   end

   // Transmit memory: host writes 32-bit lanes of a 512-bit word by strobes
   logic tx_mem_we;
   logic [MEM_BE-1:0] tx_mem_be;
   logic tx_mem_re;
   logic [MEM_AW-1:0] tx_mem_read_ptr;
   assign tx_mem_we = wr_fire & (region == RG_TXMEM);
   assign tx_mem_be = MEM_BE'({60'h0, pstrb}) << {paddr[5:2], 2'b00};

   cepb_dpram u_tx_packet_mem (
      .clk(core_clk),
      .wr_en(tx_mem_we),
      .wr_addr(paddr[11:6]),
      .wr_be(tx_mem_be),
      .wr_data({16{pwdata}}),
      .rd_en(tx_mem_re),
      .rd_addr(tx_mem_read_ptr),
      .rd_data(tx_word_data)
   );

   // Request and done cross as toggles so a pulse cannot be missed
   logic req_tgl;
   logic [1:0] req_sync;
   logic req_seen;
   logic done_tgl;
   logic [1:0] done_sync;
   logic done_seen;
   logic tx_start;
   logic tx_done_flag;
   logic [LEN_W-1:0] tx_len_hold;
   assign tx_start = req_sync[1] ^ req_seen;
   assign tx_done_flag = done_sync[1] ^ done_seen;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         tx_in_progress <= 1'b0;
         req_tgl <= 1'b0;
         tx_len_hold <= TX_LEN_RST;
         done_sync <= 2'b00;
         done_seen <= 1'b0;
      end else if (ce) begin
         done_sync <= {done_sync[0], done_tgl};
         done_seen <= done_sync[1];
         if (tx_go) begin
            tx_in_progress <= 1'b1;
            req_tgl <= ~req_tgl;
            tx_len_hold <= tx_byte_length;
         end else if (tx_done_flag) begin
            tx_in_progress <= 1'b0;
         end
      end
   end

   // Link side streamer
   cepb_tx_e tx_state;
   logic [6:0] tx_words_left;
   logic [6:0] tx_words_total;
   logic [MEM_BE-1:0] final_byte_mask;
   assign tx_words_total = tx_len_hold[12:6] + 7'(|tx_len_hold[5:0]);
   assign tx_mem_re = (tx_state == TX_FETCH) & ce;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         req_sync <= 2'b00;
         req_seen <= 1'b0;
         done_tgl <= 1'b0;
         tx_state <= TX_IDLE;
         tx_words_left <= 7'h00;
         tx_mem_read_ptr <= '0;
         final_byte_mask <= KEEP_ALL;
         tx_word_valid <= 1'b0;
         tx_final_word <= 1'b0;
         tx_byte_keep <= KEEP_ALL;
      end else if (ce) begin
         req_sync <= {req_sync[0], req_tgl};
         req_seen <= req_sync[1];
         case (tx_state)
            TX_IDLE: begin
               if (tx_start) begin
                  if (tx_words_total == 7'h00) begin
                     done_tgl <= ~done_tgl;
                  end else begin
                     tx_mem_read_ptr <= '0;
                     tx_words_left <= tx_words_total;
                     final_byte_mask <= cepb_last_mask(tx_len_hold[5:0]);
                     tx_state <= TX_FETCH;
                  end
               end
            end
            TX_FETCH: begin
               tx_word_valid <= 1'b1;
               tx_final_word <= (tx_words_left == 7'h01);
               tx_byte_keep <= (tx_words_left == 7'h01) ? final_byte_mask : KEEP_ALL;
               tx_state <= TX_SEND;
            end
            TX_SEND: begin
               // Nothing moves while ready is low
               if (tx_word_accept) begin
                  tx_word_valid <= 1'b0;
                  tx_final_word <= 1'b0;
                  tx_byte_keep <= KEEP_ALL;
                  if (tx_final_word) begin
                     done_tgl <= ~done_tgl;
                     tx_state <= TX_IDLE;
                  end else begin
                     tx_mem_read_ptr <= tx_mem_read_ptr + 6'h01;
                     tx_words_left <= tx_words_left - 7'h01;
                     tx_state <= TX_FETCH;
                  end
               end
            end
            default: tx_state <= TX_IDLE;
         endcase
      end
   end

   // Receive side settings pass a two-stage synchroniser
   logic [HDR_WORDS*32-1:0] hdr_flat;
   logic [HDR_WORDS*32-1:0] hdr_s1;
   logic [HDR_WORDS*32-1:0] expected_header;
   logic [HDR_BYTES-1:0] mask_s1;
   logic [HDR_BYTES-1:0] mask_sync;
   logic en_s1;
   logic rx_en_sync;
   logic [HDR_BYTES-1:0] header_match_bits;

   genvar gi;
   for (gi = 0; gi < HDR_WORDS; gi++) begin : g_flat
      assign hdr_flat[32*gi +: 32] = hdr_word[gi];
   end
   for (gi = 0; gi < HDR_BYTES; gi++) begin : g_cmp
      assign header_match_bits[gi] = ~mask_sync[gi] |
         (rx_in.data[8*gi +: 8] == expected_header[8*gi +: 8]);
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         hdr_s1 <= '0;
         expected_header <= '0;
         mask_s1 <= '0;
         mask_sync <= '0;
         en_s1 <= 1'b0;
         rx_en_sync <= 1'b0;
      end else if (ce) begin
         hdr_s1 <= hdr_flat;
         expected_header <= hdr_s1;
         mask_s1 <= header_byte_mask;
         mask_sync <= mask_s1;
         en_s1 <= rx_accept_enable;
         rx_en_sync <= en_s1;
      end
   end

   // Packet tracking and storage
   logic rx_mid;
   logic rx_keep;
   logic packet_start_detect;
   logic packet_end_detect;
   logic rx_accept_now;
   logic rx_mem_write_en;
   logic end_fifo_push;
   logic [MEM_AW-1:0] rx_mem_write_ptr;
   assign packet_start_detect = rx_in.valid & ~rx_mid;
   assign packet_end_detect = rx_in.valid & rx_in.last;
   assign rx_accept_now = (&header_match_bits) & rx_en_sync & ~end_fifo_fill_count[4];
   assign rx_mem_write_en = ce & rx_in.valid & (packet_start_detect ? rx_accept_now : rx_keep);
   assign end_fifo_push = rx_mem_write_en & rx_in.last;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         rx_mid <= 1'b0;
         rx_keep <= 1'b0;
         rx_mem_write_ptr <= '0;
      end else if (ce) begin
         if (rx_in.valid) rx_mid <= ~rx_in.last;
         if (packet_start_detect) rx_keep <= rx_accept_now;
         if (rx_mem_write_en) rx_mem_write_ptr <= rx_mem_write_ptr + 6'h01;
      end
   end

   cepb_dpram u_rx_packet_mem (
      .clk(core_clk),
      .wr_en(rx_mem_write_en),
      .wr_addr(rx_mem_write_ptr),
      .wr_be(KEEP_ALL),
      .wr_data(rx_in.data),
      .rd_en(psel & ~penable & ce),
      .rd_addr(paddr[11:6]),
      .rd_data(rx_mem_rdata)
   );

   // End address FIFO, head visible without a pop
   logic [MEM_AW-1:0] end_fifo_mem [2**FIFO_AW];
   logic [FIFO_AW-1:0] fifo_wr_idx;
   logic [FIFO_AW-1:0] fifo_rd_idx;
   assign end_fifo_empty = (end_fifo_fill_count == '0);
   assign end_fifo_head = end_fifo_mem[fifo_rd_idx];

   always_ff @(posedge core_clk) begin
      if (srst) begin
         fifo_wr_idx <= '0;
         fifo_rd_idx <= '0;
         end_fifo_fill_count <= '0;
      end else if (ce) begin
         if (end_fifo_push) begin
            end_fifo_mem[fifo_wr_idx] <= rx_mem_write_ptr;
            fifo_wr_idx <= fifo_wr_idx + 4'h1;
         end
         if (end_fifo_pop) fifo_rd_idx <= fifo_rd_idx + 4'h1;
         end_fifo_fill_count <= end_fifo_fill_count + 5'(end_fifo_push) - 5'(end_fifo_pop);
      end
   end

   AST_BUSY_ON_REQ: assert property (ce && tx_go |=> tx_in_progress)
      else $error("busy did not rise on request");
   AST_STALL_HOLD: assert property (ce && tx_word_valid && !tx_word_accept |=>
      tx_word_valid && $stable(tx_byte_keep) && $stable(tx_final_word)
      && $stable(tx_mem_read_ptr))
      else $error("stream changed while stalled");
   AST_KEEP_FULL: assert property (tx_word_valid && !tx_final_word |-> tx_byte_keep == KEEP_ALL)
      else $error("non-final word keep not full");
   AST_KEEP_LAST: assert property (tx_word_valid && tx_final_word |->
      tx_byte_keep == final_byte_mask && tx_words_left == 7'h01)
      else $error("final word keep or count wrong");
   AST_PTR_ADV: assert property (ce && tx_word_valid && tx_word_accept && !tx_final_word |=>
      tx_mem_read_ptr == $past(tx_mem_read_ptr) + 6'h01
      && tx_words_left == $past(tx_words_left) - 7'h01)
      else $error("read pointer or count did not advance");
   AST_DONE_CLEARS: assert property (ce && tx_word_valid && tx_word_accept && tx_final_word
      ##1 ce[*4] |=> !tx_in_progress)
      else $error("busy not cleared after final word");
   AST_REJECT_QUIET: assert property (packet_start_detect && !rx_accept_now && ce |->
      !rx_mem_write_en && !end_fifo_push ##1 (rx_mem_write_ptr == $past(rx_mem_write_ptr)))
      else $error("rejected packet touched storage");
   AST_FULL_BLOCK: assert property (end_fifo_fill_count[4] && packet_start_detect |->
      !rx_mem_write_en)
      else $error("packet stored while fifo full");
   AST_PUSH_COUNT: assert property (ce && end_fifo_push && !end_fifo_pop |=>
      end_fifo_fill_count == $past(end_fifo_fill_count) + 5'h01)
      else $error("push did not add one entry");
   AST_MATCH_ALL: assert property (rx_mem_write_en && packet_start_detect |->
      &header_match_bits)
      else $error("stored packet with header mismatch");
endmodule // cepb_top

// file: tb/cepb_mac_model.sv
// Link-side stand-in: stalling stream sink and receive packet source
`timescale 1ns/1ps
module cepb_mac_model import cepb_pkg::*; (
   input wire logic core_clk,
   input wire logic slow,
   input wire logic tx_word_valid,
   input wire logic tx_final_word,
   input wire logic [MEM_BE-1:0] tx_byte_keep,
   input wire logic [MEM_DW-1:0] tx_word_data,
   output logic tx_word_accept,
   output cepb_rx_s rx_in
);
   logic [MEM_DW-1:0] got_data [0:63];
   logic [MEM_BE-1:0] got_keep [0:63];
   logic got_last [0:63];
   int n_got = 0;
   int hold_err = 0;
   logic [3:0] cnt = 4'h0;
   logic stalled = 1'b0;
   logic [MEM_DW+MEM_BE:0] held = '0;
   initial begin
      tx_word_accept = 1'b0;
      rx_in = '0;
   end
   // Stalls come in runs so a word must be held across several edges
   always @(posedge core_clk) begin
      cnt <= cnt + 4'h1;
      tx_word_accept <= !slow || (cnt[2:1] == 2'h3);
      stalled <= tx_word_valid && !tx_word_accept;
      held <= {tx_final_word, tx_byte_keep, tx_word_data};
      if (stalled && (tx_word_valid !== 1'b1 ||
          held !== {tx_final_word, tx_byte_keep, tx_word_data})) begin
         hold_err <= hold_err + 1;
      end
      if (tx_word_valid && tx_word_accept) begin
         got_data[n_got] <= tx_word_data;
         got_keep[n_got] <= tx_byte_keep;
         got_last[n_got] <= tx_final_word;
         n_got <= n_got + 1;
      end
   end
   // Word i carries d xor i; the released bus shows the inverse, not stale data
   task automatic send_pkt(input logic [MEM_DW-1:0] d, input int words);
      for (int i = 0; i < words; i++) begin
         @(posedge core_clk);
         rx_in <= '{valid: 1'b1, last: (i == words - 1), data: d ^ MEM_DW'(i)};
      end
      @(posedge core_clk);
      rx_in <= '{valid: 1'b0, last: 1'b0, data: ~d};
   endtask
endmodule // cepb_mac_model

// file: tb/tb_cpu_ethernet_packet_buffer.sv
// Self-checking bench for the packet buffer top
`timescale 1ns/1ps
module tb_cpu_ethernet_packet_buffer import cepb_pkg::*;;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [PADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [3:0] pstrb = '0;
   logic slow = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, tx_word_valid, tx_final_word, tx_word_accept;
   logic [MEM_BE-1:0] tx_byte_keep;
   logic [MEM_DW-1:0] tx_word_data;
   cepb_rx_s rx_in;
   int n_mismatch = 0;
   int compares = 0;
   logic [31:0] rd;
   logic err;
   logic [MEM_DW-1:0] hdr = {16{32'h0F1E_2D3C}};

   cepb_top dut (.core_clk(core_clk), .srst(srst), .ce(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tx_word_valid(tx_word_valid), .tx_final_word(tx_final_word),
      .tx_byte_keep(tx_byte_keep), .tx_word_data(tx_word_data),
      .tx_word_accept(tx_word_accept), .rx_in(rx_in));
   cepb_mac_model mac (.core_clk(core_clk), .slow(slow), .tx_word_valid(tx_word_valid),
      .tx_final_word(tx_final_word), .tx_byte_keep(tx_byte_keep),
      .tx_word_data(tx_word_data), .tx_word_accept(tx_word_accept), .rx_in(rx_in));

   initial begin
      forever #25 core_clk = ~core_clk;
   end

   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input logic [MEM_DW-1:0] got, input logic [MEM_DW-1:0] exp, input string s);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t %s got %0h exp %0h", $time, s, got, exp);
      end
   endtask

   // Request held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      chk(pready, 1'b1, "apb answer");
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [13:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hF);
   endtask

   task automatic rdv(input logic [13:0] a);
      apb(1'b0, a, 32'h0, 4'hF);
   endtask

   task automatic t_idle;
      rdv(OFS_STATUS);
      chk(rd[1:0], 2'h2, "idle status");
      rdv(14'h0010);
      chk({err, rd}, {1'b1, 32'h0}, "unmapped read");
      // A pop with nothing queued must leave the count alone
      wr(OFS_CTRL, 32'h4);
      rdv(OFS_STATUS);
      chk(rd[8:0], 9'h002, "pop on empty");
   endtask

   task automatic t_tx(input logic [12:0] len, input logic stall);
      int nw;
      logic [MEM_DW-1:0] w;
      logic [MEM_BE-1:0] k;
      nw = int'(len[12:6]) + int'(len[5:0] != 6'h00);
      slow <= stall;
      mac.n_got = 0;
      for (int i = 0; i < nw * 16; i++) begin
         wr({OFS_TXMEM_TOP, 6'(i / 16), 4'(i % 16), 2'h0}, {8'(i / 16), 8'(i % 16), 16'hC35A});
      end
      apb(1'b1, {OFS_TXMEM_TOP, 12'h0}, 32'hFFFF_FFFF, 4'h3);
      wr(OFS_TX_LEN, {19'h0, len});
      wr(OFS_CTRL, 32'h1);
      rdv(OFS_STATUS);
      chk(rd[0], 1'b1, "busy after request");
      for (int n = 0; n < 300; n++) begin
         rdv(OFS_STATUS);
         if (rd[0] === 1'b0) break;
      end
      chk(rd[0], 1'b0, "busy cleared");
      chk(mac.n_got, nw, "word count");
      chk(mac.hold_err, 0, "held while stalled");
      for (int i = 0; i < nw; i++) begin
         for (int l = 0; l < 16; l++) w[32*l +: 32] = {8'(i), 8'(l), 16'hC35A};
         if (i == 0) w[15:0] = 16'hFFFF;
         k = (i == nw - 1 && len[5:0] != 6'h00) ? (64'h1 << len[5:0]) - 64'h1 : '1;
         chk(mac.got_data[i], w, "tx data");
         chk(mac.got_keep[i], k, "tx keep");
         chk(mac.got_last[i], i == nw - 1, "tx last");
      end
   endtask

   task automatic rx_cfg(input logic [37:0] m);
      for (int n = 0; n < 10; n++) wr(OFS_HDR_BASE + 14'(4 * n), hdr[32*n +: 32]);
      wr(OFS_MASK_LO, m[31:0]);
      wr(OFS_MASK_HI, {26'h0, m[37:32]});
      wr(OFS_CTRL, 32'h2);
      repeat (4) @(posedge core_clk);
   endtask

   task automatic head_pop(input logic [5:0] a);
      rdv(OFS_FIFO_HEAD);
      chk(rd[5:0], a, "fifo head");
      wr(OFS_CTRL, 32'h6);
   endtask

   task automatic t_rx;
      hdr[111:96] = 16'h0008;
      hdr[119:112] = 8'h45;
      hdr[191:184] = 8'h06;
      hdr[303:288] = 16'h1500;
      rx_cfg('1);
      mac.send_pkt(hdr, 2);
      mac.send_pkt(hdr ^ (512'h1 << 300), 1);
      wr(OFS_CTRL, 32'h0);
      // The filter sees the enable two cycles late
      repeat (2) @(posedge core_clk);
      mac.send_pkt(hdr, 1);
      wr(OFS_CTRL, 32'h2);
      rdv(OFS_STATUS);
      chk(rd[8:1], 8'h08, "one stored");
      for (int l = 0; l < 16; l++) begin
         rdv({OFS_RXMEM_TOP, 6'h1, 4'(l), 2'h0});
         chk(rd, 32'((hdr ^ 512'h1) >> (32 * l)), "rx word");
      end
      head_pop(6'h1);
      rdv(OFS_STATUS);
      chk(rd[1], 1'b1, "empty after pop");
      mac.send_pkt(hdr, 1);
      head_pop(6'h2);
      rx_cfg('0);
      for (int p = 0; p < 17; p++) mac.send_pkt(~hdr, 1);
      rdv(OFS_STATUS);
      chk(rd[8:0], 9'h100, "fifo full");
      for (int p = 0; p < 16; p++) head_pop(6'(3 + p));
      rdv(OFS_STATUS);
      chk(rd[8:1], 8'h01, "drained");
   endtask

   initial begin
      repeat (40000) @(posedge core_clk);
      n_mismatch++;
      tally_and_finish();
   end

   initial begin
      repeat (8) @(posedge core_clk);
      srst <= 1'b0;
      t_idle();
      t_tx(13'd0, 1'b0);
      t_tx(13'd133, 1'b1);
      t_tx(13'd4096, 1'b0);
      t_rx();
      tally_and_finish();
   end
endmodule // tb_cpu_ethernet_packet_buffer
